// ---- tw_ctrl_port.sv ----
// Three-wire serial control port with synthesizer power, speed-up and lock side effects
// Notes on behaviour
// [R1] With enable low, each rising shift clock edge shifts one frame bit.
// [R2] With enable high, clock and data are ignored and no register changes.
// [R3] Controller supplies enable and clock; incoming bits sampled on rising edges.
// [R4] Read data changes on falling edges; controller samples next rising edge.
// [R5] Data pin direction follows write or read, steered by the bit counter.
// [R6] Every frame is 32 bits: 7 address, 1 read/write, 24 data.
// [R7] Address arrives LSB first on rising edges 1 to 7.
// [R8] Edge 8 carries read/write: 1 writes, 0 reads.
// [R9] Write data arrives LSB first on rising edges 9 to 32.
// [R10] Edge 32 of a write stores the 24-bit word at the address.
// [R11] After edge 32 the next edge starts a new frame without toggling enable.
// [R12] Enable high aborts the frame, drops bits and clears the counter.
// [R13] Main divider write starts charge pump speed-up until another register is written.
// [R14] Power bit 1 follows chip mode; 0 follows its inverse.
// [R15] Synthesizer power-up resynchronises main and reference dividers.
// [R16] Lock reads 1 within one reference period, 0 while powered down.
// [R17] Reads drive 24 data bits LSB first on edges 9 to 32.
// [R18] Addresses 00 to 03 are write-only and never read back.
// [R19] Writes are accepted and contents kept during power-down.
// [R20] Outside a read data phase the data pin stays an input.
`timescale 1ns/1ps
module tw_ctrl_port
    import tw_pkg::*;
(
    // System clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    // Serial link pins
    input  wire logic                  shift_clock,
    input  wire logic                  serial_enable_n,
    input  wire logic                  serial_data_in,
    output logic                       serial_data_out,
    output logic                       serial_data_oe_n,
    // Analog side
    input  wire logic                  phase_lock_in,
    // Register contents and synthesizer control, system domain
    output tw_word_t [NUM_REGS-1:0]    reg_words,
    output tw_synth_ctl_t              synth_ctl
);
    // Constants the counters and indices rely on
    initial begin
        if (ADDR_W + 1 + DATA_W != FRAME_BITS) begin
            $error("frame layout does not add up");
        end
        if ((1 << CNT_W) != FRAME_BITS) begin
            $error("bit counter must wrap exactly at the frame length");
        end
        if (NUM_REGS > 16) begin
            $error("register index is only four bits wide");
        end
        if (int'(REG_LAST) != NUM_REGS - 1) begin
            $error("last address and register count disagree");
        end
        if (REG_LAST_WO >= REG_LAST) begin
            $error("no readable register left");
        end
    end

    // ---------------- Link domain ----------------
    // Frame phase follows the bit count; Gray order keeps adjacent phases one bit apart
    typedef enum logic [1:0] {
        PH_ADDR = 2'h0,
        PH_RW   = 2'h1,
        PH_DATA = 2'h3
    } tw_phase_t;

    logic [CNT_W-1:0]             bit_cnt_reg;
    logic [FRAME_BITS-2:0]        shift_reg;
    wire tw_word_t [NUM_REGS-1:0] link_regs;
    wire [NUM_REGS-1:0]           link_we;
    tw_word_t                     rd_word_reg;
    logic                         rd_active_reg;
    logic                         drive_reg;
    logic                         sdo_reg;
    logic [ADDR_W-1:0]            wr_addr_hold_reg;
    tw_word_t                     wr_data_hold_reg;
    logic                         wr_toggle_reg;

    // Frame decode
    wire tw_phase_t        frame_phase   = (bit_cnt_reg == CNT_RW_BIT)  ? PH_RW   :
                                           (bit_cnt_reg >= CNT_DATA_LO) ? PH_DATA : PH_ADDR;
    wire                   rw_edge       = (frame_phase == PH_RW);
    wire                   data_phase    = (frame_phase == PH_DATA);
    wire [FRAME_BITS-1:0]  frame_word    = {serial_data_in, shift_reg};
    wire                   frame_end     = (bit_cnt_reg == CNT_LAST);
    wire [ADDR_W-1:0]      frame_addr    = frame_word[ADDR_W-1:0];
    wire [3:0]             frame_index   = frame_addr[3:0];
    wire                   frame_write   = frame_word[ADDR_W] == RW_WRITE;
    wire tw_word_t         frame_data    = frame_word[FRAME_BITS-1 -: DATA_W];
    wire                   addr_mapped   = frame_addr <= REG_LAST;
    wire                   write_fire    = !serial_enable_n && frame_end && frame_write &&
                                           addr_mapped;
    // Read decode, resolved one edge ahead of the data phase
    wire [ADDR_W-1:0]      early_addr    = shift_reg[FRAME_BITS-2 -: ADDR_W];
    wire [3:0]             early_index   = early_addr[3:0];
    wire                   early_mapped  = early_addr <= REG_LAST;
    wire                   early_wo      = early_addr <= REG_LAST_WO;
    wire                   early_read_ok = early_mapped && !early_wo;
    wire                   rw_is_read    = serial_data_in != RW_WRITE;
    wire                   read_start    = rw_edge && rw_is_read && early_read_ok;
    wire tw_word_t         rd_pick       = link_regs[early_index];

    // Enable high acts as an asynchronous clear, so an abort needs no clock edge
    always_ff @(posedge shift_clock or posedge serial_enable_n) begin
        if (serial_enable_n) begin
            bit_cnt_reg <= '0;                                     // [R12] [R2]
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;                    // [R1] [R6] [R11]
        end
    end

    // Bits of a cut frame are dropped with the count, never reused by a later frame
    always_ff @(posedge shift_clock or posedge serial_enable_n) begin
        if (serial_enable_n) begin
            shift_reg <= '0;                                       // [R12]
        end else begin
            shift_reg <= frame_word[FRAME_BITS-1:1];               // [R3] [R7] [R9]
        end
    end

    // Contents must survive aborts, so only the system reset clears them
    for (genvar r = 0; r < NUM_REGS; r++) begin : g_link_reg
        localparam tw_word_t RST_WORD = (r == 0) ? RST_MAIN_DIV :
                                        (r == 1) ? RST_REF_DIV : RST_OTHER;
        tw_word_t word_reg;
        assign link_we[r] = write_fire && (frame_index == 4'(r));
        always_ff @(posedge shift_clock or posedge reset) begin
            if (reset) begin
                word_reg <= RST_WORD;
            end else if (link_we[r]) begin
                word_reg <= frame_data;                            // [R10] [R19]
            end
        end
        assign link_regs[r] = word_reg;
    end

    // Hold registers stay put for a whole frame after the toggle flips
    always_ff @(posedge shift_clock or posedge reset) begin
        if (reset) begin
            wr_addr_hold_reg <= '0;
            wr_data_hold_reg <= '0;
            wr_toggle_reg    <= 1'h0;
        end else if (write_fire) begin
            wr_addr_hold_reg <= frame_addr;
            wr_data_hold_reg <= frame_data;
            wr_toggle_reg    <= ~wr_toggle_reg;
        end
    end

    // Read phase opens at edge 8 and closes with the last edge of the frame
    always_ff @(posedge shift_clock or posedge serial_enable_n) begin
        if (serial_enable_n) begin
            rd_active_reg <= 1'h0;
        end else if (read_start) begin
            rd_active_reg <= 1'h1;                                 // [R8] [R5]
        end else if (frame_end) begin
            rd_active_reg <= 1'h0;                                 // [R5]
        end
    end

    // A shifting word avoids indexing past its end outside the data phase
    always_ff @(posedge shift_clock or posedge serial_enable_n) begin
        if (serial_enable_n) begin
            rd_word_reg <= '0;
        end else if (read_start) begin
            rd_word_reg <= rd_pick;                                // [R18]
        end else if (rd_active_reg && data_phase) begin
            rd_word_reg <= {1'h0, rd_word_reg[DATA_W-1:1]};        // [R17]
        end
    end

    // Falling edge launch gives the controller a full half period of setup
    always_ff @(negedge shift_clock or posedge serial_enable_n) begin
        if (serial_enable_n) begin
            drive_reg <= 1'h0;                                     // [R20]
        end else begin
            drive_reg <= rd_active_reg;                            // [R5] [R20]
        end
    end

    always_ff @(negedge shift_clock or posedge serial_enable_n) begin
        if (serial_enable_n) begin
            sdo_reg <= 1'h0;
        end else begin
            sdo_reg <= rd_active_reg & rd_word_reg[0];             // [R4] [R17]
        end
    end

    assign serial_data_out  = sdo_reg;
    assign serial_data_oe_n = ~drive_reg;                          // [R20]

    // ---------------- System domain ----------------
    logic                         wr_toggle_sync;
    logic                         wr_toggle_seen_reg;
    logic                         lock_sync;
    wire tw_word_t [NUM_REGS-1:0] sys_regs;
    wire [NUM_REGS-1:0]           sys_we;
    logic                         speedup_reg;
    logic                         power_prev_reg;
    logic                         resync_reg;
    logic                         lock_reg;

    tw_sync u_wr_sync (
        .clk (clk_sys),
        .rst (reset),
        .d   (wr_toggle_reg),
        .q   (wr_toggle_sync)
    );

    tw_sync u_lock_sync (
        .clk (clk_sys),
        .rst (reset),
        .d   (phase_lock_in),
        .q   (lock_sync)
    );

    // Hold registers are stable for many shift edges after the toggle flips
    wire       wr_event   = wr_toggle_sync != wr_toggle_seen_reg;
    wire [3:0] wr_index   = wr_addr_hold_reg[3:0];
    wire       wr_main    = wr_addr_hold_reg == REG_MAIN_DIV;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_toggle_seen_reg <= 1'h0;
        end else begin
            wr_toggle_seen_reg <= wr_toggle_sync;
        end
    end

    // System copies change only on a crossed write, a few system cycles after edge 32, possibly early in a chained frame
    for (genvar r = 0; r < NUM_REGS; r++) begin : g_sys_reg
        localparam tw_word_t RST_WORD = (r == 0) ? RST_MAIN_DIV :
                                        (r == 1) ? RST_REF_DIV : RST_OTHER;
        tw_word_t copy_reg;
        assign sys_we[r] = wr_event && (wr_index == 4'(r));
        always_ff @(posedge clk_sys) begin
            if (reset) begin
                copy_reg <= RST_WORD;
            end else if (sys_we[r]) begin
                copy_reg <= wr_data_hold_reg;                      // [R19]
            end
        end
        assign sys_regs[r] = copy_reg;
    end

    // Every mapped write moves speed-up; only the main divider word sets it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            speedup_reg <= 1'h0;
        end else if (wr_event) begin
            speedup_reg <= wr_main;                                // [R13]
        end
    end

    wire       chip_mode  = sys_regs[REG_MODE[3:0]][CHIP_MODE_BIT];
    wire       on_bit     = sys_regs[REG_REF_DIV[3:0]][ON_BIT];
    wire [1:0] lock_mode  = sys_regs[REG_REF_DIV[3:0]][LOCK_MODE_LO +: 2];
    wire       power_on   = on_bit ? chip_mode : ~chip_mode;       // [R14]
    wire       power_rise = power_on && !power_prev_reg;
    wire       lock_ok    = lock_sync && power_on && (lock_mode == LOCK_MODE_NORMAL);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            power_prev_reg <= 1'h0;
        end else begin
            power_prev_reg <= power_on;                            // [R14]
        end
    end

    // One pulse per power-up, aligned with the registered power state
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            resync_reg <= 1'h0;
        end else begin
            resync_reg <= power_rise;                              // [R15]
        end
    end

    // Gated by the live power equation so lock drops with power, never after it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lock_reg <= 1'h0;
        end else begin
            lock_reg <= lock_ok;                                   // [R16]
        end
    end

    assign reg_words = sys_regs;
    assign synth_ctl = '{power_on:   power_prev_reg,
                         div_resync: resync_reg,
                         cp_speedup: speedup_reg,
                         lock:       lock_reg};
endmodule

// ---- tw_pkg.sv ----
// Package of constants and types for the three-wire control port, plus its level synchroniser
package tw_pkg;
    localparam int unsigned ADDR_W       = 7;
    localparam int unsigned DATA_W       = 24;
    localparam int unsigned FRAME_BITS   = 32;
    localparam int unsigned NUM_REGS     = 9;
    localparam int unsigned CNT_W        = 5;
    // Bit positions within a frame, counted from zero
    localparam logic [4:0]  CNT_RW_BIT   = 5'h07;
    localparam logic [4:0]  CNT_DATA_LO  = 5'h08;
    localparam logic [4:0]  CNT_LAST     = 5'h1F;
    localparam logic        RW_WRITE     = 1'h1;
    // Register addresses
    localparam logic [6:0]  REG_MAIN_DIV = 7'h00;
    localparam logic [6:0]  REG_REF_DIV  = 7'h01;
    localparam logic [6:0]  REG_CP_CUR   = 7'h02;
    localparam logic [6:0]  REG_TEST     = 7'h03;
    localparam logic [6:0]  REG_MODE     = 7'h04;
    localparam logic [6:0]  REG_LAST_WO  = 7'h03;
    localparam logic [6:0]  REG_LAST     = 7'h08;
    // Field positions
    localparam int unsigned ON_BIT       = 9;
    localparam int unsigned LOCK_MODE_LO = 10;
    localparam int unsigned CHIP_MODE_BIT = 0;
    localparam logic [1:0]  LOCK_MODE_NORMAL = 2'h2;
    // Reset values
    localparam logic [23:0] RST_MAIN_DIV = 24'h10099C;
    localparam logic [23:0] RST_REF_DIV  = 24'h00BA50;
    localparam logic [23:0] RST_OTHER    = 24'h000000;

    typedef logic [DATA_W-1:0] tw_word_t;

    typedef struct packed {
        logic power_on;
        logic div_resync;
        logic cp_speedup;
        logic lock;
    } tw_synth_ctl_t;
endpackage

`timescale 1ns/1ps
module tw_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Level in and out
    input  wire logic d,
    output logic      q
);
    logic stage1_reg;
    logic stage2_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_reg <= 1'h0;
            stage2_reg <= 1'h0;
        end else begin
            stage1_reg <= d;
            stage2_reg <= stage1_reg;
        end
    end

    assign q = stage2_reg;
endmodule

// ---- tw_ctrl_port_properties.sv ----
// Concurrent checks on the control port's pins and system-side outputs
`timescale 1ns/1ps
module tw_ctrl_port_properties
    import tw_pkg::*;
(
    // System clock and reset
    input wire logic                  clk_sys,
    input wire logic                  reset,
    // Serial link pins
    input wire logic                  shift_clock,
    input wire logic                  serial_enable_n,
    input wire logic                  serial_data_in,
    input wire logic                  serial_data_out,
    input wire logic                  serial_data_oe_n,
    // Analog side and system outputs
    input wire logic                  phase_lock_in,
    input wire tw_word_t [NUM_REGS-1:0] reg_words,
    input wire tw_synth_ctl_t         synth_ctl
);
    wire logic pwr_eq = reg_words[1][ON_BIT] ? reg_words[4][0] : ~reg_words[4][0];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Power equation has settled long enough for the registered output to follow
    sequence s_pwr_steady;
        !$changed(pwr_eq) [*3];
    endsequence
    sequence s_powered_off;
        !synth_ctl.power_on [*2];
    endsequence
    a_oe_released: assert property (serial_enable_n [*2] |-> serial_data_oe_n)
        else $error("data pin driven while disabled");
    // Eight cycles covers the crossing of a write that ended just before disable
    a_regs_frozen: assert property (serial_enable_n [*8] |-> $stable(reg_words))
        else $error("register changed while disabled");
    a_speedup_set: assert property ($changed(reg_words[0]) |-> ##[0:2] synth_ctl.cp_speedup)
        else $error("speed-up not entered after divider write");
    a_speedup_clear: assert property ($changed(reg_words[8:1]) |-> ##[0:2] !synth_ctl.cp_speedup)
        else $error("speed-up not left after other write");
    a_power_follow: assert property (s_pwr_steady |-> synth_ctl.power_on == pwr_eq)
        else $error("power state does not follow mode");
    a_resync_pulse: assert property ($rose(synth_ctl.power_on) |-> ##[0:1] synth_ctl.div_resync)
        else $error("no divider resync on power-up");
    a_resync_single: assert property (synth_ctl.div_resync |-> synth_ctl.power_on ##1 !synth_ctl.div_resync)
        else $error("resync pulse malformed");
    a_lock_down: assert property (s_powered_off |-> !synth_ctl.lock)
        else $error("lock high while powered down");
    a_lock_mode: assert property ((reg_words[1][11:10] != LOCK_MODE_NORMAL) [*3] |-> !synth_ctl.lock)
        else $error("lock high with detector inactive");
endmodule

// ---- tw_bb_model.sv ----
// Baseband controller model driving the three-wire link
`timescale 1ns/1ps
module tw_bb_model
    import tw_pkg::*;
(
    // Link pins
    output logic      shift_clock,
    output logic      serial_enable_n,
    output logic      serial_data_in,
    input wire logic  serial_data_out,
    input wire logic  serial_data_oe_n
);
    logic drv = 1'h1;
    logic drove = 1'h0;
    initial begin
        shift_clock = 1'h0;
        // A real rising edge is needed to clear the frame state at start-up
        serial_enable_n = 1'h0;
        #2 serial_enable_n = 1'h1;
    end
    // Wire level resolved from the port's output enable alone: port data when it drives, model level otherwise
    assign serial_data_in = serial_data_oe_n ? drv : serial_data_out;
    always @(negedge serial_data_oe_n) drove = 1'h1;
    // Enable stays low at the end so frames can chain
    task automatic xfer(input logic [6:0] a, input logic rw, input tw_word_t d,
                        input int n, output tw_word_t q);
        logic [31:0] f;
        f = {d, rw, a};
        q = '0;
        if (serial_enable_n) begin
            serial_enable_n = 1'h0;
            #11;
        end
        for (int i = 0; i < n; i++) begin
            // Released line toggles so a stale level never passes for data
            drv = (rw || i < 8) ? f[i] : ~drv;
            #6 shift_clock = 1'h1;
            if (i >= 8) q[i-8] = serial_data_in;
            #6 shift_clock = 1'h0;
        end
    endtask
    task automatic release_bus();
        #6 serial_enable_n = 1'h1;
        drv = ~drv;
    endtask
    task automatic noise(input int n);
        for (int i = 0; i < n; i++) begin
            drv = i[0];
            #6 shift_clock = 1'h1;
            #6 shift_clock = 1'h0;
        end
    endtask
endmodule

// ---- tb_top.sv ----
// Self-checking testbench for the three-wire control port
`timescale 1ns/1ps
module tb_top;
    import tw_pkg::*;
    logic                    clk_sys = 1'h0;
    logic                    reset = 1'h0;
    logic                    phase_lock_in = 1'h0;
    logic                    shift_clock, serial_enable_n, serial_data_in;
    logic                    serial_data_out, serial_data_oe_n;
    tw_word_t [NUM_REGS-1:0] reg_words;
    tw_synth_ctl_t           synth_ctl;
    tw_word_t                q;
    int                      n_fail = 0;
    int                      num_checks = 0;
    int                      cycles = 0;
    int                      resync_cnt = 0;
    initial forever #4 clk_sys = ~clk_sys;
    tw_ctrl_port DUT (.clk_sys(clk_sys), .reset(reset), .shift_clock(shift_clock),
        .serial_enable_n(serial_enable_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
        .phase_lock_in(phase_lock_in), .reg_words(reg_words), .synth_ctl(synth_ctl));
    tw_bb_model bb (.shift_clock(shift_clock), .serial_enable_n(serial_enable_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_oe_n(serial_data_oe_n));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (synth_ctl.div_resync === 1'h1) resync_cnt++;
        if (cycles == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic settle();
        repeat (8) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [6:0] a, input tw_word_t d);
        bb.xfer(a, 1'h1, d, 32, q);
        bb.release_bus();
        settle();
    endtask
    task automatic t_write_read();
        bb.xfer(7'h05, 1'h1, 24'hA5C31E, 32, q);
        bb.xfer(7'h05, 1'h0, 24'h000000, 32, q);
        bb.release_bus();
        check(q, 24'hA5C31E);
        settle();
        check(reg_words[5], 24'hA5C31E);
    endtask
    task automatic t_abort();
        bb.xfer(7'h07, 1'h1, 24'hFFFFFF, 20, q);
        bb.release_bus();
        bb.noise(10);
        settle();
        check(reg_words[7], 24'h000000);
        wr(7'h07, 24'h3C5A69);
        check(reg_words[7], 24'h3C5A69);
    endtask
    task automatic t_write_only();
        for (int a = 0; a < 5; a++) begin
            bb.drove = 1'h0;
            bb.xfer(a[6:0], 1'h0, 24'h000000, 32, q);
            bb.release_bus();
            check(bb.drove, a == 4);
            if (a == 4) check(q, RST_OTHER);
        end
    endtask
    task automatic t_speedup();
        wr(REG_MAIN_DIV, 24'h1009A0);
        check(synth_ctl.cp_speedup, 1'h1);
        wr(7'h06, 24'h000111);
        check(synth_ctl.cp_speedup, 1'h0);
    endtask
    task automatic t_power();
        wr(REG_MODE, 24'h000001);
        check(synth_ctl.power_on, 1'h1);
        check(synth_ctl.lock, 1'h0);
        phase_lock_in = 1'h1;
        settle();
        check(synth_ctl.lock, 1'h1);
        wr(REG_REF_DIV, 24'h00B250);
        check(synth_ctl.lock, 1'h0);
        wr(REG_REF_DIV, 24'h00B850);
        check(synth_ctl.power_on, 1'h0);
        wr(7'h08, 24'h0002AB);
        check(reg_words[8], 24'h0002AB);
        wr(REG_MODE, 24'h000000);
        check(synth_ctl.power_on, 1'h1);
        check(synth_ctl.lock, 1'h1);
        check(resync_cnt, 2);
    endtask
    initial begin
        // The link-side store clears only on a rising reset edge
        #1 reset = 1'h1;
        repeat (3) @(negedge clk_sys);
        reset = 1'h0;
        repeat (4) @(negedge clk_sys);
        t_write_read();
        t_abort();
        t_write_only();
        t_speedup();
        t_power();
        stop_test();
    end
endmodule
bind tw_ctrl_port tw_ctrl_port_properties chk (.clk_sys(clk_sys), .reset(reset),
    .shift_clock(shift_clock), .serial_enable_n(serial_enable_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .phase_lock_in(phase_lock_in),
    .reg_words(reg_words), .synth_ctl(synth_ctl));
